// [hdl/spes_pkg.sv]
package spes_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEL_TMO = 8'h04;
  localparam logic [7:0] REG_DISC_TMO = 8'h08;
  localparam logic [7:0] REG_OP_TMO = 8'h0C;
  localparam logic [7:0] REG_PHASE_MASK = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SENSE = 8'h18;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_INHIBIT_BIT = 1;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_SCSI_LSB = 16;

  // reset values
  localparam logic [15:0] TMO_RESET = 16'h0000;
  localparam logic [7:0] PHASE_MASK_RESET = 8'hCF;

  // error codes posted in the status block
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_HOST_BUS = 8'h15;
  localparam logic [7:0] ERR_OP_TIMEOUT = 8'h16;
  localparam logic [7:0] ERR_SEL_TIMEOUT = 8'h1E;
  localparam logic [7:0] ERR_DISC_TIMEOUT = 8'h1F;
  localparam logic [7:0] ERR_PARITY = 8'h20;
  localparam logic [7:0] ERR_BUS_FREE = 8'h21;
  localparam logic [7:0] ERR_BAD_STATUS = 8'h23;
  localparam logic [7:0] ERR_BAD_PHASE = 8'h24;

  // scsi status byte values
  localparam logic [7:0] SCSI_GOOD = 8'h00;
  localparam logic [7:0] SCSI_CHECK = 8'h02;

  // timeout tick timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TMO_TICK_NS = 1000;
  localparam int TICK_CYCLES = (TMO_TICK_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECT = 3'b001,
    ST_CONN = 3'b010,
    ST_DISC = 3'b011,
    ST_SENSE = 3'b100
  } spes_state_t;
endpackage

// [hdl/spes_tmr_if.sv]
`timescale 1ns/1ps
interface spes_tmr_if;
  logic run;
  logic [15:0] limit;
  logic expired;
  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface

// [hdl/spes_timer.sv]
`timescale 1ns/1ps
module spes_timer
  import spes_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  spes_tmr_if.tmr t
);
  logic [15:0] pre_reg;
  logic [15:0] cnt_reg;
  logic fired_reg;
  logic exp_reg;
  wire tick = (pre_reg == 16'(TICK_CYC - 1));
  wire hit = t.run && !fired_reg && (t.limit != 16'h0000) &&
    (cnt_reg >= t.limit);

  // counts ticks while run is high, clears when it drops; zero limit = off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      fired_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else if (!t.run) begin
      pre_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      fired_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
      if (tick && cnt_reg != 16'hFFFF) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
      fired_reg <= fired_reg | hit;
      exp_reg <= hit;
    end
  end

  assign t.expired = exp_reg;
endmodule

// [hdl/spes_core.sv]
`timescale 1ns/1ps
module spes_core
  import spes_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic host_bus_err,
  input wire logic sel_ack,
  input wire logic disc_msg,
  input wire logic reselect,
  input wire logic parity_err,
  input wire logic bus_free,
  input wire logic phase_valid,
  input wire logic [2:0] phase,
  input wire logic status_valid,
  input wire logic [7:0] status_byte,
  input wire logic sense_valid,
  input wire logic [31:0] sense_data,
  output logic sel_go,
  output logic sense_req,
  output logic cmd_abort,
  output logic cmd_done,
  output logic cmd_busy,
  output logic [7:0] err_code
);
  spes_state_t st_reg;
  spes_state_t st_next;
  logic [15:0] sel_tmo_reg;
  logic [15:0] disc_tmo_reg;
  logic [15:0] op_tmo_reg;
  logic [7:0] phase_mask_reg;
  logic inhibit_reg;
  logic [7:0] code_reg;
  logic [7:0] scsi_stat_reg;
  logic [31:0] sense_reg;
  logic done_reg;
  logic stat_seen_reg;
  logic disc_pend_reg;
  logic sel_go_reg;
  logic sense_req_reg;
  logic abort_reg;
  logic done_pulse_reg;
  logic [31:0] rdata_reg;
  logic finish;
  logic [7:0] fin_code;

  spes_tmr_if sel_t ();
  spes_tmr_if disc_t ();
  spes_tmr_if op_t ();

  // one timer each for selection, disconnect and whole operation
  spes_timer u_sel_tmr (.clk(clk), .sys_rst(sys_rst), .t(sel_t));
  spes_timer u_disc_tmr (.clk(clk), .sys_rst(sys_rst), .t(disc_t));
  spes_timer u_op_tmr (.clk(clk), .sys_rst(sys_rst), .t(op_t));

  // register decode
  wire busy = (st_reg != ST_IDLE);
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_sel = reg_wr && (reg_addr == REG_SEL_TMO);
  wire wr_disc = reg_wr && (reg_addr == REG_DISC_TMO);
  wire wr_op = reg_wr && (reg_addr == REG_OP_TMO);
  wire wr_mask = reg_wr && (reg_addr == REG_PHASE_MASK);
  wire start_cmd = wr_ctrl && reg_wdata[CTRL_START_BIT] && !busy;

  // timers run only in the states they guard
  assign sel_t.run = (st_reg == ST_SELECT);
  assign sel_t.limit = sel_tmo_reg;
  assign disc_t.run = (st_reg == ST_DISC);
  assign disc_t.limit = disc_tmo_reg;
  assign op_t.run = busy;
  assign op_t.limit = op_tmo_reg;

  // error detection, each qualified by where it can legally happen
  wire connected = (st_reg == ST_CONN);
  wire bus_err_hit = busy && host_bus_err;
  wire op_hit = busy && op_t.expired;
  wire sel_hit = sel_t.run && sel_t.expired;
  wire disc_hit = disc_t.run && disc_t.expired;
  wire par_hit = connected && parity_err;
  wire phase_ok = phase_mask_reg[phase];
  wire phase_hit = connected && phase_valid && !phase_ok;
  wire bf_expected = stat_seen_reg || disc_pend_reg;
  wire bf_hit = connected && bus_free && !bf_expected;
  wire any_err = bus_err_hit || op_hit || sel_hit || disc_hit ||
    par_hit || phase_hit || bf_hit;

  // status byte handling
  wire bad_stat = (scsi_stat_reg != SCSI_GOOD);
  wire want_sense = (scsi_stat_reg == SCSI_CHECK) && !inhibit_reg;
  wire stat_take = connected && status_valid && !stat_seen_reg;
  wire clean_free = connected && bus_free && bf_expected && !any_err;
  wire go_disc = clean_free && !stat_seen_reg && disc_pend_reg;
  wire go_sense = clean_free && stat_seen_reg && want_sense;
  wire ok_end = clean_free && stat_seen_reg && !want_sense;
  wire sense_end = (st_reg == ST_SENSE) && sense_valid && !any_err;

  // first condition found ends the command with a single code
  always_comb begin
    finish = 1'b0;
    fin_code = ERR_NONE;
    if (busy) begin
      if (bus_err_hit) begin
        finish = 1'b1;
        fin_code = ERR_HOST_BUS;
      end else if (par_hit) begin
        finish = 1'b1;
        fin_code = ERR_PARITY;
      end else if (phase_hit) begin
        finish = 1'b1;
        fin_code = ERR_BAD_PHASE;
      end else if (bf_hit) begin
        finish = 1'b1;
        fin_code = ERR_BUS_FREE;
      end else if (sel_hit) begin
        finish = 1'b1;
        fin_code = ERR_SEL_TIMEOUT;
      end else if (disc_hit) begin
        finish = 1'b1;
        fin_code = ERR_DISC_TIMEOUT;
      end else if (op_hit) begin
        finish = 1'b1;
        fin_code = ERR_OP_TIMEOUT;
      end else if (ok_end) begin
        finish = 1'b1;
        fin_code = bad_stat ? ERR_BAD_STATUS : ERR_NONE;
      end else if (sense_end) begin
        finish = 1'b1;
        fin_code = ERR_BAD_STATUS;
      end
    end
  end

  // command sequence
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (start_cmd) begin
          st_next = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (finish) begin
          st_next = ST_IDLE;
        end else if (sel_ack) begin
          st_next = ST_CONN;
        end
      end
      ST_CONN: begin
        if (finish) begin
          st_next = ST_IDLE;
        end else if (go_disc) begin
          st_next = ST_DISC;
        end else if (go_sense) begin
          st_next = ST_SENSE;
        end
      end
      ST_DISC: begin
        if (finish) begin
          st_next = ST_IDLE;
        end else if (reselect) begin
          st_next = ST_CONN;
        end
      end
      ST_SENSE: begin
        if (finish) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // software configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_tmo_reg <= TMO_RESET;
      disc_tmo_reg <= TMO_RESET;
      op_tmo_reg <= TMO_RESET;
      phase_mask_reg <= PHASE_MASK_RESET;
      inhibit_reg <= 1'b0;
    end else begin
      if (wr_sel) sel_tmo_reg <= reg_wdata[15:0];
      if (wr_disc) disc_tmo_reg <= reg_wdata[15:0];
      if (wr_op) op_tmo_reg <= reg_wdata[15:0];
      if (wr_mask) phase_mask_reg <= reg_wdata[7:0];
      if (start_cmd) inhibit_reg <= reg_wdata[CTRL_INHIBIT_BIT];
    end
  end

  // sequence flags: status seen, disconnect message pending
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_seen_reg <= 1'b0;
      disc_pend_reg <= 1'b0;
    end else if (start_cmd || st_next == ST_IDLE) begin
      stat_seen_reg <= 1'b0;
      disc_pend_reg <= 1'b0;
    end else begin
      if (stat_take) stat_seen_reg <= 1'b1;
      if (connected && disc_msg) begin
        disc_pend_reg <= 1'b1;
      end else if (st_reg == ST_DISC && reselect) begin
        disc_pend_reg <= 1'b0;
      end
    end
  end

  // status block: code, scsi status and selected sense bytes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_reg <= ERR_NONE;
      scsi_stat_reg <= SCSI_GOOD;
      sense_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else if (start_cmd) begin
      code_reg <= ERR_NONE;
      scsi_stat_reg <= SCSI_GOOD;
      sense_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else begin
      if (stat_take) scsi_stat_reg <= status_byte;
      if (sense_end) sense_reg <= sense_data;
      if (finish) begin
        code_reg <= fin_code;
        done_reg <= 1'b1;
      end
    end
  end

  // one-cycle notices to the scsi engine and the host side
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_go_reg <= 1'b0;
      sense_req_reg <= 1'b0;
      abort_reg <= 1'b0;
      done_pulse_reg <= 1'b0;
    end else begin
      sel_go_reg <= start_cmd;
      sense_req_reg <= go_sense && !finish;
      abort_reg <= finish && any_err;
      done_pulse_reg <= finish;
    end
  end

  // read mux, data stands only in the cycle after the strobe
  wire [31:0] stat_word = {8'h00, scsi_stat_reg, code_reg, 6'b00_0000,
    done_reg, busy};
  wire [31:0] rd_word =
    (reg_addr == REG_CTRL) ? {30'h0000_0000, inhibit_reg, 1'b0} :
    (reg_addr == REG_SEL_TMO) ? {16'h0000, sel_tmo_reg} :
    (reg_addr == REG_DISC_TMO) ? {16'h0000, disc_tmo_reg} :
    (reg_addr == REG_OP_TMO) ? {16'h0000, op_tmo_reg} :
    (reg_addr == REG_PHASE_MASK) ? {24'h00_0000, phase_mask_reg} :
    (reg_addr == REG_STATUS) ? stat_word :
    (reg_addr == REG_SENSE) ? sense_reg : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_rd ? rd_word : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sel_go = sel_go_reg;
  assign sense_req = sense_req_reg;
  assign cmd_abort = abort_reg;
  assign cmd_done = done_pulse_reg;
  assign cmd_busy = busy;
  assign err_code = code_reg;
endmodule

// [bench/spes_core_sva.sv]
`timescale 1ns/1ps
module spes_core_sva
  import spes_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic host_bus_err,
  input wire logic sel_ack,
  input wire logic disc_msg,
  input wire logic reselect,
  input wire logic parity_err,
  input wire logic bus_free,
  input wire logic phase_valid,
  input wire logic sense_valid,
  input wire logic sel_go,
  input wire logic sense_req,
  input wire logic cmd_abort,
  input wire logic cmd_done,
  input wire logic cmd_busy,
  input wire logic [7:0] err_code
);
  logic acked_reg, disc_reg, inh_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // remember selection answer, pending disconnect and sense inhibit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acked_reg <= 1'b0;
      disc_reg <= 1'b0;
      inh_reg <= 1'b0;
    end else begin
      acked_reg <= sel_go ? 1'b0 : (acked_reg | sel_ack);
      disc_reg <= (sel_go | reselect) ? 1'b0 : (disc_reg | disc_msg);
      if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT] &&
          !cmd_busy) begin
        inh_reg <= reg_wdata[CTRL_INHIBIT_BIT];
      end
    end
  end
  host_err_end_a: assert property (host_bus_err && cmd_busy |=>
    cmd_done && cmd_abort && err_code == ERR_HOST_BUS)
    else $error("host bus error did not end the command");
  op_tmo_a: assert property (cmd_done && err_code == ERR_OP_TIMEOUT
    |-> cmd_abort) else $error("operation timeout without abort");
  sel_tmo_a: assert property (cmd_done && err_code == ERR_SEL_TIMEOUT
    |-> cmd_abort && !acked_reg) else $error("bad selection timeout");
  disc_tmo_a: assert property (cmd_done && err_code == ERR_DISC_TIMEOUT
    |-> cmd_abort && disc_reg) else $error("bad disconnect timeout");
  parity_cause_a: assert property (cmd_done && err_code == ERR_PARITY
    |-> $past(parity_err)) else $error("parity code without cause");
  free_cause_a: assert property (cmd_done && err_code == ERR_BUS_FREE
    |-> $past(bus_free && !disc_reg)) else $error("bus free code wrong");
  sense_end_a: assert property (sense_valid && cmd_busy |=>
    cmd_done && !cmd_abort && err_code == ERR_BAD_STATUS)
    else $error("sense arrival did not end with bad status");
  sense_inh_a: assert property (inh_reg && cmd_busy |-> !sense_req)
    else $error("sense fetched while inhibited");
  phase_cause_a: assert property (cmd_done && err_code == ERR_BAD_PHASE
    |-> $past(phase_valid)) else $error("phase code without cause");
  done_end_a: assert property (cmd_done |-> !cmd_busy ##1 !cmd_done)
    else $error("done pulse wrong");
  abort_done_a: assert property (cmd_abort |-> cmd_done)
    else $error("abort without done");
  cover property (cmd_done && err_code == ERR_NONE);
  cover property (sense_req);
  cover property (cmd_done && err_code == ERR_SEL_TIMEOUT);
endmodule
bind spes_core spes_core_sva chk (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .host_bus_err, .sel_ack, .disc_msg, .reselect, .parity_err,
  .bus_free, .phase_valid, .sense_valid, .sel_go, .sense_req, .cmd_abort,
  .cmd_done, .cmd_busy, .err_code);

// [bench/spes_target.sv]
`timescale 1ns/1ps
module spes_target
  import spes_pkg::*;
#(
  parameter logic [31:0] SENSE_W = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic [3:0] mode,
  input wire logic sel_go,
  input wire logic sense_req,
  output logic host_bus_err,
  output logic sel_ack,
  output logic disc_msg,
  output logic reselect,
  output logic parity_err,
  output logic bus_free,
  output logic phase_valid,
  output logic status_valid,
  output logic sense_valid,
  output logic [2:0] phase,
  output logic [7:0] status_byte,
  output logic [31:0] sense_data
);
  logic [8:0] ev = 9'h000;
  logic [7:0] st = 8'h00;
  logic [7:0] noise = 8'h5A;
  // event pulses and data; idle data lines change every cycle
  assign {host_bus_err, sel_ack, disc_msg, reselect, parity_err, bus_free,
    phase_valid, status_valid, sense_valid} = ev;
  assign status_byte = status_valid ? st : noise;
  assign phase = phase_valid ? st[2:0] : noise[2:0];
  assign sense_data = sense_valid ? SENSE_W : {4{noise}};
  always @(posedge clk) noise <= noise + 8'h3B;
  // one event pulse, then one quiet cycle
  task automatic step(input logic [8:0] v, input logic [7:0] s);
    ev <= v;
    st <= s;
    @(posedge clk);
    ev <= 9'h000;
    @(posedge clk);
  endtask
  // scripted target behaviour per mode after each selection
  initial begin
    forever begin
      @(posedge clk);
      if (sel_go === 1'b1) begin
        if (mode != 4'd5) step(9'h080, 8'h00);
        case (mode)
          4'd0: step(9'h002, SCSI_GOOD);
          4'd1: step(9'h002, SCSI_CHECK);
          4'd2: step(9'h004, 8'h00); // allowed phase first
          4'd3: step(9'h004, 8'h04); // phase masked at reset
          4'd6: step(9'h040, 8'h00);
          4'd7: step(9'h100, 8'h00);
          4'd8: step(9'h040, 8'h00);
          4'd10: step(9'h002, 8'h08);
          default: ;
        endcase
        if (mode == 4'd2) step(9'h010, 8'h00);
        if (mode == 4'd8) step(9'h008, 8'h00);
        if (mode == 4'd8) step(9'h020, 8'h00);
        if (mode == 4'd8) step(9'h002, SCSI_GOOD);
        if (mode inside {4'd0, 4'd1, 4'd4, 4'd6, 4'd8, 4'd10})
          step(9'h008, 8'h00);
      end
    end
  end
  // answer a sense fetch
  always @(posedge clk) if (sense_req === 1'b1) step(9'h001, 8'h00);
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, a) begin \
  checks++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, a); \
  end \
end
module testbench
  import spes_pkg::*;
;
  localparam logic [31:0] SNS = 32'h7000_0506;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [3:0] mode = 4'd0;
  logic [31:0] reg_rdata, sense_data, d;
  logic host_bus_err, sel_ack, disc_msg, reselect, parity_err, bus_free;
  logic phase_valid, status_valid, sense_valid, sel_go, sense_req;
  logic cmd_abort, cmd_done, cmd_busy;
  logic [2:0] phase;
  logic [7:0] status_byte, err_code;
  int n_errors = 0, checks = 0;
  spes_core dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .host_bus_err, .sel_ack, .disc_msg, .reselect, .parity_err,
    .bus_free, .phase_valid, .phase, .status_valid, .status_byte,
    .sense_valid, .sense_data, .sel_go, .sense_req, .cmd_abort, .cmd_done,
    .cmd_busy, .err_code);
  spes_target #(.SENSE_W(SNS)) tgt (.clk, .mode, .sel_go, .sense_req,
    .host_bus_err, .sel_ack, .disc_msg, .reselect, .parity_err, .bus_free,
    .phase_valid, .status_valid, .sense_valid, .phase, .status_byte,
    .sense_data);
  always #2 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // run one command and check its ending and status block
  task automatic cmd(input logic [3:0] m, input logic [31:0] c,
      input logic [7:0] code, input logic ab, input logic [7:0] sst,
      input logic [31:0] sns);
    int i;
    logic ab_seen;
    mode <= m;
    wr(REG_CTRL, c);
    i = 0;
    while (cmd_done !== 1'b1 && i < 3000) begin
      @(posedge clk);
      #1 i++;
    end
    ab_seen = cmd_abort;
    `CHK("cmd_done", 1'b1, cmd_done)
    `CHK("cmd_abort", ab, ab_seen)
    `CHK("err_code", code, err_code)
    rd(REG_STATUS, d);
    `CHK("status", {8'h00, sst, code, 8'h02}, d)
    rd(REG_SENSE, d);
    `CHK("sense", sns, d)
    $display("test mode %0d done", m);
  endtask
  // reset values, unmapped place, then at least one command per ending
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    wr(8'h1C, 32'hFFFF_FFFF);
    for (int k = 0; k < 8; k++) begin
      rd(8'(4 * k), d);
      `CHK("reset value", (k == 4) ? 32'h0000_00CF : 32'h0000_0000, d)
    end
    $display("test registers done");
    wr(REG_SEL_TMO, 32'h0000_0001);
    wr(REG_DISC_TMO, 32'h0000_0001);
    wr(REG_OP_TMO, 32'h0000_0004);
    cmd(4'd0, 32'h1, ERR_NONE, 1'b0, 8'h00, 32'h0);
    cmd(4'd8, 32'h1, ERR_NONE, 1'b0, 8'h00, 32'h0);
    cmd(4'd7, 32'h1, ERR_HOST_BUS, 1'b1, 8'h00, 32'h0);
    cmd(4'd2, 32'h1, ERR_PARITY, 1'b1, 8'h00, 32'h0);
    cmd(4'd3, 32'h1, ERR_BAD_PHASE, 1'b1, 8'h00, 32'h0);
    // phase 0 barred by software: first phase is now unexpected
    wr(REG_PHASE_MASK, 32'h0000_00FE);
    rd(REG_PHASE_MASK, d);
    `CHK("phase mask", 32'h0000_00FE, d)
    cmd(4'd2, 32'h1, ERR_BAD_PHASE, 1'b1, 8'h00, 32'h0);
    wr(REG_PHASE_MASK, {24'h00_0000, PHASE_MASK_RESET});
    $display("test phase mask done");
    cmd(4'd4, 32'h1, ERR_BUS_FREE, 1'b1, 8'h00, 32'h0);
    cmd(4'd5, 32'h1, ERR_SEL_TIMEOUT, 1'b1, 8'h00, 32'h0);
    cmd(4'd6, 32'h1, ERR_DISC_TIMEOUT, 1'b1, 8'h00, 32'h0);
    cmd(4'd9, 32'h1, ERR_OP_TIMEOUT, 1'b1, 8'h00, 32'h0);
    cmd(4'd10, 32'h1, ERR_BAD_STATUS, 1'b0, 8'h08, 32'h0);
    cmd(4'd1, 32'h1, ERR_BAD_STATUS, 1'b0, SCSI_CHECK, SNS);
    cmd(4'd1, 32'h3, ERR_BAD_STATUS, 1'b0, SCSI_CHECK, 32'h0);
    rd(REG_CTRL, d);
    `CHK("inhibit readback", 32'h0000_0002, d)
    // start while busy is ignored, then a reset cuts the command
    mode <= 4'd9;
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_CTRL, d);
    `CHK("start while busy", 32'h0000_0000, d)
    rd(REG_STATUS, d);
    `CHK("busy status", 32'h0000_0001, d)
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_STATUS, d);
    `CHK("status after reset", 32'h0000_0000, d)
    rd(REG_OP_TMO, d);
    `CHK("op limit after reset", 32'h0000_0000, d)
    $display("test mid reset done");
    finish_test;
  end
  // cut a hang short
  initial begin
    #100_000;
    n_errors++;
    finish_test;
  end
endmodule
